// ===== logic/serial_flash_opcode_decoder.v
// serial flash opcode decoder: decodes host instructions, returns status/id/data
// assumes host link pins are asynchronous and sampled by i_sys_clk (link clock <= ~1/8 rate)
`timescale 1ns/1ps
`default_nettype none
`include "serial_flash_opcode_map.vh"
module serial_flash_opcode_decoder #(
  parameter [7:0] MAKER_ID = 8'h5a, // arbitrary value
  parameter [7:0] PART_ID = 8'h3c, // arbitrary value
  parameter [15:0] JEDEC_PART = 16'h4d_21, // arbitrary value
  parameter [63:0] UNIQUE_ID = 64'h0123_4567_89ab_cdef, // arbitrary value
  parameter integer BUSY_CYCLES = `BUSY_CYCLES
) (
  input wire i_sys_clk, // system clock
  input wire i_rst, // async reset, high
  input wire i_sel_n, // host select, low active
  input wire i_sclk, // host serial clock
  input wire i_serial_in_pin, // host data / dual_line_zero input
  input wire i_dual_line_one, // dual line one input
  output reg o_serial_out_pin, // single output / dual line one out
  output reg o_out_oe, // output line drive enable
  output reg o_dual_line_zero, // dual line zero out
  output reg o_dual_zero_oe, // dual line zero drive enable
  output wire o_data_valid, // array data byte request valid
  output wire [23:0] o_data_addr, // array byte address
  input wire i_data_ready, // array accepts address
  input wire i_rd_valid, // array read byte valid
  input wire [7:0] i_rd_data, // array read byte
  output wire o_rd_ready, // buffer has room
  output reg o_prog_valid, // program byte pulse
  output reg [7:0] o_prog_data, // program byte
  output reg o_busy // internal cycle running
);
  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  reg [1:0] sel_sync_reg, clk_sync_reg, d0_sync_reg, d1_sync_reg;
  reg clk_last_reg;
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sel_sync_reg <= 2'b11;
      clk_sync_reg <= 2'b00;
      d0_sync_reg <= 2'b00;
      d1_sync_reg <= 2'b00;
      clk_last_reg <= 1'b0;
    end else begin
      sel_sync_reg <= {sel_sync_reg[0], i_sel_n};
      clk_sync_reg <= {clk_sync_reg[0], i_sclk};
      d0_sync_reg <= {d0_sync_reg[0], i_serial_in_pin};
      d1_sync_reg <= {d1_sync_reg[0], i_dual_line_one};
      clk_last_reg <= clk_sync_reg[1];
    end
  end
  wire sel_active = ~sel_sync_reg[1];
  wire rise = sel_active & clk_sync_reg[1] & ~clk_last_reg;
  wire fall = sel_active & ~clk_sync_reg[1] & clk_last_reg;
  // ----------------------------------------------------------------
  // instruction state
  // ----------------------------------------------------------------
  localparam [3:0] S_OPCODE = 4'b0001;
  localparam [3:0] S_FIELD = 4'b0010;
  localparam [3:0] S_REPLY = 4'b0100;
  localparam [3:0] S_IGNORE = 4'b1000;
  reg [3:0] state_reg;
  reg [7:0] op_reg;
  reg [7:0] shift_reg;
  reg [6:0] bit_cnt_reg; // bits (or dual pairs) since field start
  reg [5:0] field_len_reg; // field length in clocks
  reg [23:0] addr_reg;
  reg dual_in_reg;
  reg [63:0] out_reg;
  reg [6:0] out_cnt_reg;
  reg sel_was_reg;
  reg write_latch_flag_reg, vol_en_reg, power_down_reg, wr_pending_reg;
  reg [7:0] prot_reg;
  reg [7:0] status_next;
  reg [15:0] busy_cnt_reg;
  reg [1:0] pend_kind_reg; // 0 none 1 status write 2 erase/program
  // ----------------------------------------------------------------
  // two-entry read buffer
  // ----------------------------------------------------------------
  reg [7:0] buf_mem [0:1];
  reg buf_wr_reg, buf_rd_reg;
  reg [1:0] buf_cnt_reg;
  wire buf_pop;
  assign o_rd_ready = (buf_cnt_reg != 2'd2);
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      buf_wr_reg <= 1'b0;
      buf_rd_reg <= 1'b0;
      buf_cnt_reg <= 2'd0;
    end else if (sel_sync_reg[1]) begin
      buf_wr_reg <= 1'b0;
      buf_rd_reg <= 1'b0;
      buf_cnt_reg <= 2'd0;
    end else begin
      if (i_rd_valid && o_rd_ready) begin
        buf_mem[buf_wr_reg] <= i_rd_data;
        buf_wr_reg <= ~buf_wr_reg;
      end
      if (buf_pop) buf_rd_reg <= ~buf_rd_reg;
      buf_cnt_reg <= buf_cnt_reg + {1'b0, (i_rd_valid && o_rd_ready)} - {1'b0, buf_pop};
    end
  end
  wire is_stream = (op_reg == `OP_READ) || (op_reg == `OP_FAST_READ) || (op_reg == `OP_DUAL_OUT);
  wire is_dual_out = (op_reg == `OP_DUAL_OUT) || (op_reg == `OP_MAKER_ID_DUAL);
  // address requests run ahead; the buffer absorbs up to two in flight
  reg [1:0] req_cnt_reg;
  reg req_on_reg, req_hold_reg;
  // a request once shown is held through deselect until the array takes it
  assign o_data_valid = req_hold_reg ||
    (req_on_reg && ({1'b0, req_cnt_reg} + {1'b0, buf_cnt_reg} < 3'd2) && sel_active);
  assign o_data_addr = addr_reg;
  wire req_take = o_data_valid && i_data_ready;
  wire byte_edge = fall && (state_reg == S_REPLY) &&
    (out_cnt_reg == (is_dual_out ? 7'd3 : 7'd7));
  // stream bytes load on the fall that sends their top bit, not one fall late
  wire byte_start = fall && (state_reg == S_REPLY) && is_stream && (out_cnt_reg == 7'd0);
  wire [63:0] out_word = byte_start ? {((buf_cnt_reg != 2'd0) ? buf_mem[buf_rd_reg] : 8'h00), 56'h0} : out_reg;
  assign buf_pop = byte_start && (buf_cnt_reg != 2'd0);
  always @* begin
    status_next = prot_reg & `ST_PROT_MASK;
    status_next[`ST_BUSY_BIT] = o_busy;
    status_next[`ST_WEL_BIT] = write_latch_flag_reg;
  end
  // field length in clocks after the opcode
  function [5:0] field_clocks;
    input [7:0] op;
    begin
      case (op)
        `OP_READ, `OP_PROGRAM, `OP_ERASE_4K, `OP_ERASE_32K, `OP_ERASE_64K, `OP_WAKE_ID, `OP_MAKER_ID: field_clocks = 6'd24;
        `OP_FAST_READ, `OP_DUAL_OUT, `OP_UNIQUE_ID: field_clocks = (op == `OP_UNIQUE_ID) ? 6'd32 : 6'd32;
        `OP_MAKER_ID_DUAL, `OP_DUAL_IO: field_clocks = 6'd16;
        `OP_WRITE_STATUS: field_clocks = 6'd8;
        default: field_clocks = 6'd0;
      endcase
    end
  endfunction
  // ----------------------------------------------------------------
  // main decoder
  // ----------------------------------------------------------------
  wire [7:0] op_now = {shift_reg[6:0], d0_sync_reg[1]};
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= S_OPCODE;
      op_reg <= 8'h00;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 7'd0;
      field_len_reg <= 6'd0;
      addr_reg <= 24'h00_0000;
      dual_in_reg <= 1'b0;
      out_reg <= 64'h0;
      out_cnt_reg <= 7'd0;
      sel_was_reg <= 1'b0;
      write_latch_flag_reg <= 1'b0;
      vol_en_reg <= 1'b0;
      power_down_reg <= 1'b0;
      wr_pending_reg <= 1'b0;
      prot_reg <= 8'h00;
      busy_cnt_reg <= 16'h0000;
      pend_kind_reg <= 2'd0;
      o_busy <= 1'b0;
      o_prog_valid <= 1'b0;
      o_prog_data <= 8'h00;
      o_serial_out_pin <= 1'b0;
      o_out_oe <= 1'b0;
      o_dual_line_zero <= 1'b0;
      o_dual_zero_oe <= 1'b0;
      req_on_reg <= 1'b0;
      req_cnt_reg <= 2'd0;
      req_hold_reg <= 1'b0;
    end else begin
      o_prog_valid <= 1'b0;
      req_hold_reg <= o_data_valid && !i_data_ready;
      sel_was_reg <= sel_active;
      if (req_take) begin
        addr_reg <= addr_reg + 24'd1;
      end
      req_cnt_reg <= req_cnt_reg + {1'b0, req_take} - {1'b0, i_rd_valid && o_rd_ready && req_cnt_reg != 2'd0};
      if (o_busy) begin
        if (busy_cnt_reg == 16'd0) begin
          o_busy <= 1'b0;
          write_latch_flag_reg <= 1'b0;
        end else begin
          busy_cnt_reg <= busy_cnt_reg - 16'd1;
        end
      end
      if (!sel_active) begin
        if (sel_was_reg && state_reg != S_IGNORE && bit_cnt_reg[2:0] == 3'd0) begin
          case (op_reg)
            `OP_WRITE_EN: write_latch_flag_reg <= 1'b1;
            `OP_VOL_WRITE_EN: vol_en_reg <= 1'b1;
            `OP_WRITE_DIS: begin
              write_latch_flag_reg <= 1'b0;
              vol_en_reg <= 1'b0;
            end
            `OP_POWER_DOWN: power_down_reg <= 1'b1;
            default: begin
              if (wr_pending_reg) begin
                if (vol_en_reg && op_reg == `OP_WRITE_STATUS) begin
                  vol_en_reg <= 1'b0;
                end else begin
                  o_busy <= 1'b1;
                  busy_cnt_reg <= BUSY_CYCLES[15:0];
                end
              end
            end
          endcase
        end
        wr_pending_reg <= 1'b0;
        state_reg <= S_OPCODE;
        bit_cnt_reg <= 7'd0;
        op_reg <= 8'h00;
        req_on_reg <= 1'b0;
        req_cnt_reg <= 2'd0;
        o_out_oe <= 1'b0;
        o_dual_zero_oe <= 1'b0;
      end else if (rise) begin
        shift_reg <= dual_in_reg ? {shift_reg[5:0], d1_sync_reg[1], d0_sync_reg[1]} : op_now;
        bit_cnt_reg <= bit_cnt_reg + 7'd1;
        case (state_reg)
          S_OPCODE: begin
            if (bit_cnt_reg == 7'd7) begin
              op_reg <= op_now;
              bit_cnt_reg <= 7'd0;
              field_len_reg <= field_clocks(op_now);
              dual_in_reg <= (op_now == `OP_MAKER_ID_DUAL) || (op_now == `OP_DUAL_IO);
              if ((o_busy && op_now != `OP_READ_STATUS) || (power_down_reg && op_now != `OP_WAKE_ID)) begin
                state_reg <= S_IGNORE;
              end else if (op_now == `OP_READ_STATUS) begin
                state_reg <= S_REPLY;
                out_reg <= {status_next, 56'h0};
                out_cnt_reg <= 7'd0;
              end else if (op_now == `OP_JEDEC_ID) begin
                state_reg <= S_REPLY;
                out_reg <= {MAKER_ID, JEDEC_PART, 40'h0};
                out_cnt_reg <= 7'd0;
              end else if (field_clocks(op_now) != 6'd0) begin
                state_reg <= S_FIELD;
              end else begin
                case (op_now)
                  `OP_WRITE_EN, `OP_VOL_WRITE_EN, `OP_WRITE_DIS, `OP_POWER_DOWN: state_reg <= S_FIELD;
                  `OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B: begin
                    state_reg <= S_FIELD;
                    wr_pending_reg <= write_latch_flag_reg;
                  end
                  default: state_reg <= S_IGNORE;
                endcase
              end
            end
          end
          S_FIELD: begin
            if (field_len_reg != 6'd0 && bit_cnt_reg[5:0] == field_len_reg - 6'd1) begin
              dual_in_reg <= 1'b0;
              bit_cnt_reg <= 7'd0;
              field_len_reg <= 6'd0;
              out_cnt_reg <= 7'd0;
              case (op_reg)
                `OP_ERASE_4K, `OP_ERASE_32K, `OP_ERASE_64K: wr_pending_reg <= write_latch_flag_reg;
                `OP_WRITE_STATUS: begin
                  if (write_latch_flag_reg || vol_en_reg) begin
                    prot_reg <= op_now & `ST_PROT_MASK;
                    wr_pending_reg <= 1'b1;
                  end
                end
                `OP_PROGRAM: wr_pending_reg <= write_latch_flag_reg;
                `OP_WAKE_ID: begin
                  power_down_reg <= 1'b0;
                  state_reg <= S_REPLY;
                  out_reg <= {PART_ID, 56'h0};
                end
                `OP_MAKER_ID: begin
                  state_reg <= S_REPLY;
                  out_reg <= {MAKER_ID, PART_ID, 48'h0};
                end
                `OP_MAKER_ID_DUAL: begin
                  state_reg <= S_REPLY;
                  out_reg <= {MAKER_ID, PART_ID, 48'h0};
                end
                `OP_UNIQUE_ID: begin
                  state_reg <= S_REPLY;
                  out_reg <= UNIQUE_ID;
                end
                `OP_READ, `OP_FAST_READ, `OP_DUAL_OUT: begin
                  state_reg <= S_REPLY;
                  req_on_reg <= 1'b1;
                end
                default: state_reg <= S_IGNORE;
              endcase
            end else if (field_len_reg == 6'd0 && op_reg == `OP_PROGRAM && bit_cnt_reg[2:0] == 3'd7) begin
              o_prog_valid <= 1'b1;
              o_prog_data <= op_now;
            end
            if (bit_cnt_reg < 7'd24 && op_reg != `OP_WRITE_STATUS && field_len_reg != 6'd0 && !dual_in_reg) begin
              addr_reg <= {addr_reg[22:0], d0_sync_reg[1]};
            end else if (dual_in_reg && bit_cnt_reg < 7'd12) begin
              addr_reg <= {addr_reg[21:0], d1_sync_reg[1], d0_sync_reg[1]};
            end
          end
          default: begin
          end
        endcase
      end else if (fall && state_reg == S_REPLY) begin
        o_serial_out_pin <= out_word[63];
        if (is_dual_out) begin
          o_dual_line_zero <= out_word[62];
          o_dual_zero_oe <= 1'b1;
          out_reg <= {out_word[61:0], 2'b00};
        end else begin
          out_reg <= {out_word[62:0], 1'b0};
        end
        o_out_oe <= 1'b1;
        out_cnt_reg <= out_cnt_reg + 7'd1;
        if (byte_edge) begin
          out_cnt_reg <= 7'd0;
          if (op_reg == `OP_READ_STATUS) begin
            out_reg <= {status_next, 56'h0};
          end else if (op_reg == `OP_WAKE_ID) begin
            out_reg <= {PART_ID, 56'h0};
          end
        end
      end
    end
  end
endmodule // serial_flash_opcode_decoder
`default_nettype wire

// ===== logic/serial_flash_opcode_map.vh
// serial flash opcode decoder: opcodes, status bits and timing counts
// assumes a single system clock that samples the host link pins
`ifndef SERIAL_FLASH_OPCODE_MAP_VH
`define SERIAL_FLASH_OPCODE_MAP_VH
`define OP_WRITE_EN 8'h06
`define OP_VOL_WRITE_EN 8'h50
`define OP_WRITE_DIS 8'h04
`define OP_READ_STATUS 8'h05
`define OP_WRITE_STATUS 8'h01
`define OP_READ 8'h03
`define OP_FAST_READ 8'h0b
`define OP_DUAL_OUT 8'h3b
`define OP_DUAL_IO 8'hbb
`define OP_PROGRAM 8'h02
`define OP_ERASE_4K 8'h20
`define OP_ERASE_32K 8'h52
`define OP_ERASE_64K 8'hd8
`define OP_CHIP_ERASE_A 8'hc7
`define OP_CHIP_ERASE_B 8'h60
`define OP_POWER_DOWN 8'hb9
`define OP_WAKE_ID 8'hab
`define OP_MAKER_ID 8'h90
`define OP_MAKER_ID_DUAL 8'h92
`define OP_JEDEC_ID 8'h9f
`define OP_UNIQUE_ID 8'h4b
`define ST_BUSY_BIT 0
`define ST_WEL_BIT 1
`define ST_PROT_MASK 8'hac
`define BUSY_TIME_NS 1000
`define CLK_PERIOD_NS 4
`define BUSY_CYCLES (`BUSY_TIME_NS / `CLK_PERIOD_NS)
`endif

// ===== dv/serial_flash_opcode_decoder_assertions.sv
// checker: port timing of the opcode decoder
// assumes binding onto the decoder, one clock domain
`timescale 1ns/1ps
`default_nettype none
module serial_flash_opcode_decoder_assertions #(
  parameter integer BUSY_CYCLES = 250
) (
  input wire logic i_sys_clk, // clock
  input wire logic i_rst, // reset
  input wire logic i_sel_n, // select
  input wire logic i_sclk, // link clock
  input wire logic i_data_ready, // array ready
  input wire logic i_rd_valid, // reply valid
  input wire logic o_rd_ready, // buffer room
  input wire logic o_serial_out_pin, // line one
  input wire logic o_out_oe, // line one enable
  input wire logic o_dual_line_zero, // line zero
  input wire logic o_dual_zero_oe, // line zero enable
  input wire logic o_data_valid, // request
  input wire logic [23:0] o_data_addr, // request address
  input wire logic o_prog_valid, // program pulse
  input wire logic o_busy // busy
);
  int busy_cnt;
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= o_busy ? busy_cnt + 1 : 0;
    end
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // --------------------------------
  // assertions
  // --------------------------------
  oe_idle_a: assert property (i_sel_n [*8] |-> !o_out_oe)
    else $error("line one driven while deselected");
  zero_idle_a: assert property (i_sel_n [*8] |-> !o_dual_zero_oe)
    else $error("line zero driven while deselected");
  commit_desel_a: assert property ($rose(o_busy) |-> i_sel_n && $past(i_sel_n))
    else $error("busy started inside a frame");
  busy_len_a: assert property ($fell(o_busy) |-> busy_cnt >= BUSY_CYCLES - 2 && busy_cnt <= BUSY_CYCLES + 2)
    else $error("busy length wrong");
  out_fall_a: assert property (o_out_oe && $past(o_out_oe) && $changed(o_serial_out_pin) |-> !i_sclk)
    else $error("line one changed with link clock high");
  zero_fall_a: assert property (o_dual_zero_oe && $past(o_dual_zero_oe) && $changed(o_dual_line_zero) |-> !i_sclk)
    else $error("line zero changed with link clock high");
  prog_pulse_a: assert property (o_prog_valid |=> !o_prog_valid)
    else $error("program strobe longer than one cycle");
  req_hold_a: assert property (o_data_valid && !i_data_ready |=> o_data_valid && $stable(o_data_addr))
    else $error("array request dropped before ready");
  cover property ($rose(o_busy));
  cover property ($rose(o_dual_zero_oe));
  cover property (i_rd_valid && !o_rd_ready);
endmodule // serial_flash_opcode_decoder_assertions
bind serial_flash_opcode_decoder serial_flash_opcode_decoder_assertions #(.BUSY_CYCLES(BUSY_CYCLES)) chk_u (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_sel_n(i_sel_n), .i_sclk(i_sclk), .i_data_ready(i_data_ready),
  .i_rd_valid(i_rd_valid), .o_rd_ready(o_rd_ready), .o_serial_out_pin(o_serial_out_pin), .o_out_oe(o_out_oe),
  .o_dual_line_zero(o_dual_line_zero), .o_dual_zero_oe(o_dual_zero_oe), .o_data_valid(o_data_valid),
  .o_data_addr(o_data_addr), .o_prog_valid(o_prog_valid), .o_busy(o_busy));
`default_nettype wire

// ===== dv/host_spi_model.sv
// host link master: frames opcode, fields and reply bytes
// assumes the bench resolves line levels from all enables
`timescale 1ns/1ps
`default_nettype none
module host_spi_model (
  output logic o_sel_n, // select, low active
  output logic o_sclk, // link clock, idles low
  output logic o_d0, // line zero drive
  output logic o_d0_oe, // line zero enable
  output logic o_d1, // line one drive
  output logic o_d1_oe, // line one enable
  input wire logic i_line0, // resolved line zero
  input wire logic i_line1 // resolved line one
);
  logic [7:0] rxq[$];
  initial begin
    o_sel_n = 1'b1;
    o_sclk = 1'b0;
    {o_d0, o_d0_oe, o_d1, o_d1_oe} = 4'h0;
  end
  // stop > 0 cuts the frame after that many clocks
  task automatic xfer(input logic [7:0] op, input int ntx, input logic [63:0] txd, input int txw,
                      input int nrx, input int rxw, input int stop);
    logic [71:0] sh;
    logic [7:0] rb;
    int nclk, tot, b;
    sh = {op, 64'(txd << (64 - 8 * ntx))};
    nclk = 8 + ntx * 8 / txw;
    tot = (stop > 0) ? stop : nclk + nrx * 8 / rxw;
    b = 0;
    #0.7 o_sel_n = 1'b0;
    for (int k = 0; k < tot; k++) begin
      if (k < nclk) begin
        o_d0_oe = 1'b1;
        o_d1_oe = (k >= 8 && txw == 2);
        {o_d1, o_d0} = o_d1_oe ? sh[71:70] : {1'b0, sh[71]};
        sh = o_d1_oe ? sh << 2 : sh << 1;
      end else begin
        {o_d0_oe, o_d1_oe} = 2'b00;
      end
      #40 o_sclk = 1'b1;
      if (k >= nclk) begin
        rb = (rxw == 2) ? {rb[5:0], i_line1, i_line0} : {rb[6:0], i_line1};
        b += rxw;
        if (b == 8) begin
          rxq.push_back(rb);
          b = 0;
        end
      end
      #40 o_sclk = 1'b0;
    end
    #20 o_sel_n = 1'b1;
    {o_d0_oe, o_d1_oe} = 2'b00;
    #100;
  endtask
endmodule // host_spi_model
`default_nettype wire

// ===== dv/serial_flash_opcode_decoder_test.sv
// bench: host frames in, replies compared from an expectation queue
// assumes the decoder, its opcode header and the host model
`timescale 1ns/1ps
`default_nettype none
`include "serial_flash_opcode_map.vh"
module serial_flash_opcode_decoder_test;
  localparam int BUSY_N = 800;
  localparam logic [7:0] MK = 8'h3e; // arbitrary value
  localparam logic [7:0] PT = 8'h71; // arbitrary value
  localparam logic [15:0] JP = 16'h2c94; // arbitrary value
  localparam logic [63:0] UID = 64'h1f2e_3d4c_5b6a_7988; // arbitrary value
  logic clk = 0, rst = 1, junk = 0, i_data_ready = 0, i_rd_valid = 0, acc_q, acc_r;
  logic [7:0] i_rd_data = 0, acc_a, pb, r;
  logic [15:0] e;
  logic [23:0] a;
  logic [7:0] pend[$];
  logic [15:0] expq[$];
  logic [7:0] rops[3] = '{`OP_READ, `OP_FAST_READ, `OP_DUAL_OUT};
  int fail_count = 0, samples_checked = 0, cyc = 0, pcnt = 0;
  wire h_sel_n, h_sclk, h_d0, h_d0_oe, h_d1, h_d1_oe, o_serial_out_pin, o_out_oe, o_dual_line_zero;
  wire o_dual_zero_oe, o_data_valid, o_rd_ready, o_prog_valid, o_busy;
  wire [23:0] o_data_addr;
  wire [7:0] o_prog_data;
  // released lines show a moving pattern, never the last value
  wire line0 = h_d0_oe ? h_d0 : (o_dual_zero_oe ? o_dual_line_zero : junk);
  wire line1 = h_d1_oe ? h_d1 : (o_out_oe ? o_serial_out_pin : junk);
  host_spi_model host_u (.o_sel_n(h_sel_n), .o_sclk(h_sclk), .o_d0(h_d0), .o_d0_oe(h_d0_oe), .o_d1(h_d1),
    .o_d1_oe(h_d1_oe), .i_line0(line0), .i_line1(line1));
  serial_flash_opcode_decoder #(.MAKER_ID(MK), .PART_ID(PT), .JEDEC_PART(JP), .UNIQUE_ID(UID),
    .BUSY_CYCLES(BUSY_N)) dut_u (.i_sys_clk(clk), .i_rst(rst), .i_sel_n(h_sel_n), .i_sclk(h_sclk),
    .i_serial_in_pin(line0), .i_dual_line_one(line1), .o_serial_out_pin(o_serial_out_pin), .o_out_oe(o_out_oe),
    .o_dual_line_zero(o_dual_line_zero), .o_dual_zero_oe(o_dual_zero_oe), .o_data_valid(o_data_valid),
    .o_data_addr(o_data_addr), .i_data_ready(i_data_ready), .i_rd_valid(i_rd_valid), .i_rd_data(i_rd_data),
    .o_rd_ready(o_rd_ready), .o_prog_valid(o_prog_valid), .o_prog_data(o_prog_data), .o_busy(o_busy));
  initial begin
    forever #2 clk = ~clk;
  end
  // --------------------------------
  // array model and checking
  // --------------------------------
  always @(negedge clk) begin
    {acc_q, acc_a, acc_r} = {o_data_valid && i_data_ready, o_data_addr[7:0], i_rd_valid && o_rd_ready};
    if (host_u.rxq.size() > 0) begin
      r = host_u.rxq.pop_front();
      e = 'x;
      if (expq.size() > 0) e = expq.pop_front();
      check("reply", r & e[15:8], e[7:0]);
    end
    if (o_prog_valid === 1'b1) begin
      pcnt++;
      check("prog byte", o_prog_data, pb);
    end
  end
  always @(posedge clk) begin
    #1;
    junk = ~junk;
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      finish_test();
    end
    i_data_ready = ($urandom % 4) != 0;
    if (acc_r === 1'b1) void'(pend.pop_front());
    if (acc_q === 1'b1) pend.push_back(acc_a ^ 8'h5a);
    // a shown byte holds until the buffer takes it; about one update in eight leaves a gap
    if (acc_r === 1'b1 || !i_rd_valid) begin
      i_rd_valid = pend.size() > 0 && ($urandom % 8 != 0);
      if (pend.size() > 0) i_rd_data = pend[0];
    end
  end
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic ex(input logic [7:0] v, input logic [7:0] m = 8'hff);
    expq.push_back({m, v});
  endtask
  task automatic st(input logic [7:0] v, input logic [7:0] m = 8'hff);
    ex(v, m);
    ex(v, m);
    host_u.xfer(`OP_READ_STATUS, 0, 0, 1, 2, 1, 0);
  endtask
  task automatic cmd(input logic [7:0] op);
    host_u.xfer(op, 0, 0, 1, 0, 1, 0);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h2649_9657));
    repeat (2) @(posedge clk);
    #1 rst = 0;
    repeat (8) @(posedge clk);
    st(8'h00);
    cmd(`OP_WRITE_EN);
    st(8'h02);
    cmd(`OP_WRITE_DIS);
    st(8'h00);
    cmd(`OP_VOL_WRITE_EN);
    st(8'h00);
    a = 24'($urandom);
    cmd(`OP_WRITE_EN);
    host_u.xfer(`OP_ERASE_4K, 3, a, 1, 0, 1, 28);
    st(8'h02);
    pb = 8'($urandom);
    host_u.xfer(`OP_PROGRAM, 4, {a, pb}, 1, 0, 1, 0);
    st(8'h01, 8'h01);
    for (int i = 0; i < 4000 && o_busy !== 1'b0; i++) @(posedge clk);
    st(8'h00);
    // volatile status write takes no busy time
    host_u.xfer(`OP_WRITE_STATUS, 1, a, 1, 0, 1, 0);
    st(a[7:0] & `ST_PROT_MASK);
    ex(MK);
    ex(JP[15:8]);
    ex(JP[7:0]);
    host_u.xfer(`OP_JEDEC_ID, 0, 0, 1, 3, 1, 0);
    ex(MK);
    ex(PT);
    host_u.xfer(`OP_MAKER_ID, 3, 0, 1, 2, 1, 0);
    ex(MK);
    ex(PT);
    host_u.xfer(`OP_MAKER_ID_DUAL, 4, {a, 8'h00}, 2, 2, 2, 0);
    for (int i = 0; i < 8; i++) ex(UID[63 - 8 * i -: 8]);
    host_u.xfer(`OP_UNIQUE_ID, 4, $urandom, 1, 8, 1, 0);
    cmd(`OP_POWER_DOWN);
    ex(PT);
    ex(PT);
    host_u.xfer(`OP_WAKE_ID, 3, $urandom, 1, 2, 1, 0);
    foreach (rops[j]) begin
      a = 24'($urandom);
      ex(a[7:0] ^ 8'h5a);
      ex((a[7:0] + 8'h01) ^ 8'h5a);
      host_u.xfer(rops[j], j ? 4 : 3, j ? {a, 8'h00} : a, 1, 2, (j == 2) ? 2 : 1, 0);
    end
    repeat (100) @(posedge clk);
    check("pending", 8'(expq.size()), 8'h00);
    check("prog count", 8'(pcnt), 8'h01);
    finish_test();
  end
endmodule // serial_flash_opcode_decoder_test
`default_nettype wire
